// ---- src/lss_status.v ----
// line state recognizer and read-only status registers of the ring phy controller
`timescale 1ns/1ps
`include "lss_map.vh"

module lss_status #(
   parameter ADDR_W = 5
) (
   input  wire              clock,
   input  wire              rst_n,
   input  wire              pair_valid,
   input  wire [2:0]        pair_class,
   input  wire [1:0]        repeat_filter_state,
   input  wire [1:0]        insertion_state,
   input  wire              scrubbing_flag,
   input  wire [3:0]        conn_mgmt_state,
   input  wire [ADDR_W-1:0] reg_addr,
   input  wire [15:0]       reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [15:0]       reg_rdata_ff,
   output reg  [2:0]        current_line_state_ff,
   output reg               line_state_unknown_flag_ff,
   output reg               irq_ff
);

   ////////////////////////////////////////////////////////////////////////////////
   // notes for whoever wires this block in
   //
   // receive side
   //   one pair_valid cycle is one received symbol pair, never a single symbol
   //   the class code comes from the receive decoder, already framed on pairs
   //   classes 2 and 7 carry no meaning here and are taken as noise
   //   pair_valid may stay high for a run; every high cycle counts one pair
   //
   // recognizer behaviour
   //   a pair that differs from the candidate restarts the count from zero
   //   so a new state needs eight pairs counted from its own first pair
   //   idle is the exception: two pairs give the short idle code
   //   staying on idle for eight pairs upgrades it to the long idle code
   //   while hunting, the code keeps the last recognized state
   //   software then sees the old code plus the unknown flag, never a guess
   //   once locked the counter parks at its last value, except on short idle where it counts on to seven; it is not free running
   //   the state bit is high while locked, low while hunting
   //
   // mirrored fields
   //   repeat filter and management fields are only mirrored here; insertion is mirrored and also watched for changes
   //   their machines run elsewhere and must be synchronous to this clock
   //   no sampling stage is added, so a read shows the value of its strobe cycle
   //   the low seven bits of the connection word are left at zero
   //
   // register port
   //   both status words are live and read-only; no read clears anything
   //   writes to the status words decode to nothing and are simply dropped
   //   read data stand for one cycle only and are zero otherwise,
   //   which lets several banks share one or-ed read bus
   //   the port never stalls, so back-to-back strobes are all served
   //
   // interrupts
   //   two events: line state code changed, insertion state changed
   //   only the interrupt status word is write-one-to-clear
   //   a change and a clear in the same cycle leave the bit set,
   //   so an event is never lost to a late clear
   //   the level output follows status and mask by one clock
   //
   // limitations
   //   the line status upper byte is left at zero
   //   there is no previous-state history; only the current code is kept
   //   there is no long-count timer; all timing is counted in pairs

   ////////////////////////////////////////////////////////////////////////////////
   // recognizer state: one-hot, hunting for a new state or locked on one
   localparam ST_HUNT = 2'b01;
   localparam ST_LOCK = 2'b10;

   // recognizer state, pair counter and the candidate being counted
   reg [1:0]  state_ff;
   reg [1:0]  nxt_state;
   reg [2:0]  like_pair_counter_ff;
   reg [2:0]  nxt_like_pair_counter;
   reg [2:0]  cand_ff;
   reg [2:0]  nxt_cand;
   // next values of the two recognizer outputs
   reg [2:0]  nxt_line_state;
   reg        nxt_unknown;
   // interrupt side: insertion edge detector, sticky status and mask
   reg [1:0]  ins_prev_ff;
   reg [`LSS_INT_W-1:0] int_status_ff;
   reg [`LSS_INT_W-1:0] int_mask_ff;

   // maps a symbol class to the line state it would establish
   function [2:0] class_to_state;
      input [2:0] cls;
      begin
         case (cls)
            `LSS_SYM_DATA:   class_to_state = `LSS_LS_ACTIVE;
            `LSS_SYM_IDLE:   class_to_state = `LSS_LS_IDLE4;
            `LSS_SYM_QUIET:  class_to_state = `LSS_LS_QUIET;
            `LSS_SYM_MASTER: class_to_state = `LSS_LS_MASTER;
            `LSS_SYM_HALT:   class_to_state = `LSS_LS_HALT;
            default:         class_to_state = `LSS_LS_NOISE;
         endcase
      end
   endfunction

   // one step of the pair counter; three bits wrap, but no path asks past seven
   function [2:0] count_step;
      input [2:0] cnt;
      begin
         count_step = cnt + 3'h1;
      end
   endfunction

   // counter value that accepts a candidate: idle needs two pairs, the rest eight
   function [2:0] accept_goal;
      input [2:0] cand;
      begin
         if (cand == `LSS_LS_IDLE4) begin
            accept_goal = `LSS_PAIRS_SHORT;
         end else begin
            accept_goal = `LSS_PAIRS_FULL;
         end
      end
   endfunction

   wire [2:0] pair_state = class_to_state(pair_class);
   wire       same_pair  = (pair_state == cand_ff);
   // idle is recognized after two pairs, every other state after eight
   wire [2:0] goal       = accept_goal(cand_ff);
   wire [2:0] cnt_next   = count_step(like_pair_counter_ff);

   ////////////////////////////////////////////////////////////////////////////////
   // recognizer next state
   always @* begin
      nxt_state             = state_ff;
      nxt_like_pair_counter = like_pair_counter_ff;
      nxt_cand              = cand_ff;
      nxt_line_state        = current_line_state_ff;
      nxt_unknown           = line_state_unknown_flag_ff;
      if (pair_valid) begin
         case (state_ff)
            ST_HUNT: begin
               if (!same_pair) begin
                  nxt_cand              = pair_state;
                  nxt_like_pair_counter = 3'h0;
               end else if (cnt_next >= goal) begin
                  // enough like pairs: load the candidate and lock on it
                  nxt_like_pair_counter = cnt_next;
                  nxt_line_state        = cand_ff;
                  nxt_unknown           = 1'b0;
                  nxt_state             = ST_LOCK;
               end else begin
                  // still short of the goal: keep counting, code unchanged
                  nxt_like_pair_counter = cnt_next;
               end
            end
            ST_LOCK: begin
               if (!same_pair) begin
                  nxt_cand              = pair_state;
                  nxt_like_pair_counter = 3'h0;
                  nxt_unknown           = 1'b1;
                  nxt_state             = ST_HUNT;
               end else if (cand_ff == `LSS_LS_IDLE4 &&
                            current_line_state_ff == `LSS_LS_IDLE4) begin
                  // idle keeps counting to eight pairs, i.e. sixteen symbols
                  if (like_pair_counter_ff == `LSS_PAIRS_FULL - 3'h1) begin
                     nxt_like_pair_counter = `LSS_PAIRS_FULL;
                     nxt_line_state        = `LSS_LS_IDLE16;
                  end else begin
                     // short idle held: count on towards the long idle code
                     nxt_like_pair_counter = cnt_next;
                  end
               end
            end
            default: begin
               nxt_state = ST_HUNT;
            end
         endcase
      end
   end

   // recognizer registers; comes out of reset hunting with noise shown
   always @(posedge clock) begin
      if (!rst_n) begin
         state_ff                   <= ST_HUNT;
         like_pair_counter_ff       <= 3'h0;
         cand_ff                    <= `LSS_LS_NOISE;
         current_line_state_ff      <= `LSS_LS_NOISE;
         line_state_unknown_flag_ff <= 1'b1;
      end else begin
         state_ff                   <= nxt_state;
         like_pair_counter_ff       <= nxt_like_pair_counter;
         cand_ff                    <= nxt_cand;
         current_line_state_ff      <= nxt_line_state;
         line_state_unknown_flag_ff <= nxt_unknown;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status word fields; live values, so a read never disturbs them
   wire        recognizer_state_bit = (state_ff == ST_LOCK);
   wire [7:0]  line_upper_zero      = 8'h00;                  // upper byte unused
   wire [1:0]  rf_field             = repeat_filter_state;
   wire [1:0]  ins_field            = insertion_state;
   wire        scrub_field          = scrubbing_flag;
   wire [3:0]  cm_field             = conn_mgmt_state;
   wire [6:0]  conn_lower_zero      = 7'h00;                  // flags kept elsewhere

   // line status: code, state bit, unknown flag, pair counter
   wire [15:0] line_status_word = {line_upper_zero,
                                   current_line_state_ff,
                                   recognizer_state_bit,
                                   line_state_unknown_flag_ff,
                                   like_pair_counter_ff};

   // connection status: mirrored as-is, the owning machines live elsewhere
   wire [15:0] conn_status_word = {rf_field,
                                   ins_field,
                                   scrub_field,
                                   cm_field,
                                   conn_lower_zero};

   ////////////////////////////////////////////////////////////////////////////////
   // events: line state change and insertion state change
   // line change looks at the next value so the sticky bit rises with the new code
   wire line_chg = (nxt_line_state != current_line_state_ff);
   wire ins_chg  = (insertion_state != ins_prev_ff);
   wire [`LSS_INT_W-1:0] events = {ins_chg, line_chg};

   // register port decodes; the two status words have no write decode at all
   wire wr_clr  = reg_wr && (reg_addr == `LSS_ADDR_INT_STATUS);
   wire wr_mask = reg_wr && (reg_addr == `LSS_ADDR_INT_MASK);

   // next values of the interrupt side and of the read data
   reg [`LSS_INT_W-1:0] clr_bits;
   reg [`LSS_INT_W-1:0] nxt_int_status;
   reg [`LSS_INT_W-1:0] nxt_int_mask;
   reg                  nxt_irq;
   reg [15:0]           nxt_reg_rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // sticky status, write one to clear; a fresh event wins over the clear
   always @* begin
      clr_bits       = wr_clr ? reg_wdata[`LSS_INT_W-1:0] : {`LSS_INT_W{1'b0}};
      nxt_int_status = (int_status_ff & ~clr_bits) | events;
      nxt_int_mask   = wr_mask ? reg_wdata[`LSS_INT_W-1:0] : int_mask_ff;
      // one clock of lag buys a clean registered pin
      nxt_irq        = |(int_status_ff & int_mask_ff);
   end

   // interrupt registers; the edge detector loads the live pins in reset,
   // so a nonzero insertion state at release is not taken for a change
   always @(posedge clock) begin
      if (!rst_n) begin
         int_status_ff <= {`LSS_INT_W{1'b0}};
         int_mask_ff   <= {`LSS_INT_W{1'b0}};
         ins_prev_ff   <= insertion_state;
         irq_ff        <= 1'b0;
      end else begin
         ins_prev_ff   <= insertion_state;
         int_status_ff <= nxt_int_status;
         int_mask_ff   <= nxt_int_mask;
         irq_ff        <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; only the strobe cycle loads data, all else returns zero
   always @* begin
      nxt_reg_rdata = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `LSS_ADDR_LINE_STATUS: nxt_reg_rdata = line_status_word;
            `LSS_ADDR_CONN_STATUS: nxt_reg_rdata = conn_status_word;
            `LSS_ADDR_INT_STATUS:  nxt_reg_rdata = {14'h0000, int_status_ff};
            `LSS_ADDR_INT_MASK:    nxt_reg_rdata = {14'h0000, int_mask_ff};
            default:               nxt_reg_rdata = 16'h0000;
         endcase
      end
   end

   // read data register: data one cycle after the strobe
   always @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata_ff <= 16'h0000;
      end else begin
         reg_rdata_ff <= nxt_reg_rdata;
      end
   end

endmodule // lss_status

// ---- pkg/lss_map.vh ----
// register offsets, field positions and encodings of the line state status bank
`ifndef LSS_MAP_VH
`define LSS_MAP_VH

// register offsets (word index on the plain register port)
`define LSS_ADDR_LINE_STATUS 5'h10
`define LSS_ADDR_CONN_STATUS 5'h11
`define LSS_ADDR_INT_STATUS  5'h12
`define LSS_ADDR_INT_MASK    5'h13

// line state codes
`define LSS_LS_NOISE   3'h0
`define LSS_LS_ACTIVE  3'h1
`define LSS_LS_IDLE4   3'h3
`define LSS_LS_QUIET   3'h4
`define LSS_LS_MASTER  3'h5
`define LSS_LS_HALT    3'h6
`define LSS_LS_IDLE16  3'h7

// symbol classes presented by the receive decoder
`define LSS_SYM_OTHER  3'h0
`define LSS_SYM_DATA   3'h1
`define LSS_SYM_IDLE   3'h3
`define LSS_SYM_QUIET  3'h4
`define LSS_SYM_MASTER 3'h5
`define LSS_SYM_HALT   3'h6

// pair counts: counter value at which a state is accepted
`define LSS_PAIRS_FULL  3'h7
`define LSS_PAIRS_SHORT 3'h1

// line status field positions
`define LSS_CURRENT_LINE_STATE_LSB  5
`define LSS_RSTATE_BIT   4
`define LSS_UNKNOWN_BIT  3

// connection status field positions
`define LSS_RF_LSB     14
`define LSS_INS_LSB    12
`define LSS_SCRUB_BIT  11
`define LSS_CM_LSB     7

// interrupt status bits
`define LSS_INT_LINE_CHG 0
`define LSS_INT_INS_CHG  1
`define LSS_INT_W        2

`endif

// ---- bench/lss_status_asserts.sv ----
// concurrent checks on the ports of the line state status bank
`timescale 1ns/1ps
`include "lss_map.vh"
module lss_status_asserts #(
   parameter ADDR_W = 5
) (
   input wire              clock,
   input wire              rst_n,
   input wire              pair_valid,
   input wire [2:0]        pair_class,
   input wire [1:0]        repeat_filter_state,
   input wire [1:0]        insertion_state,
   input wire              scrubbing_flag,
   input wire [3:0]        conn_mgmt_state,
   input wire [ADDR_W-1:0] reg_addr,
   input wire              reg_rd,
   input wire [15:0]       reg_rdata_ff,
   input wire [2:0]        current_line_state_ff,
   input wire              line_state_unknown_flag_ff
);
default clocking cb @(posedge clock); endclocking
default disable iff (!rst_n);
// live connection word as the read should capture it
wire [15:0] conn_word = {repeat_filter_state, insertion_state, scrubbing_flag,
                         conn_mgmt_state, 7'h00};
// a quiet pair seeds a fresh candidate, so the runs below start counting from zero
sequence s_seed; pair_valid && pair_class == `LSS_SYM_QUIET; endsequence
sequence s_idle2; (pair_valid && pair_class == `LSS_SYM_IDLE) [*2]; endsequence
sequence s_halt7; (pair_valid && pair_class == `LSS_SYM_HALT) [*7]; endsequence
a_rdata_idle_zero:
   assert property (!reg_rd |=> reg_rdata_ff == 16'h0000) else $error("stray read data");
a_conn_read_map:
   assert property (reg_rd && reg_addr == `LSS_ADDR_CONN_STATUS |=>
      reg_rdata_ff == $past(conn_word)) else $error("connection status word wrong");
a_line_read_map:
   assert property (reg_rd && reg_addr == `LSS_ADDR_LINE_STATUS |=> reg_rdata_ff[15:8] == 8'h00
      && reg_rdata_ff[7:5] == $past(current_line_state_ff) && reg_rdata_ff[3] ==
      $past(line_state_unknown_flag_ff) && reg_rdata_ff[4] == !reg_rdata_ff[3])
      else $error("line word wrong");
a_unmapped_zero:
   assert property (reg_rd && (reg_addr < 5'h10 || reg_addr > 5'h13) |=> reg_rdata_ff == 16'h0000)
      else $error("unmapped read not zero");
a_lock_clears_unknown:
   assert property ($past(rst_n) && $changed(current_line_state_ff) |-> !line_state_unknown_flag_ff)
      else $error("state loaded while unknown");
a_idle_two_pairs:
   assert property (s_seed ##1 s_idle2 |=> current_line_state_ff == `LSS_LS_IDLE4)
      else $error("short idle not taken");
a_halt_eight_pairs:
   assert property (s_seed ##1 s_halt7 ##1 pair_valid && pair_class == `LSS_SYM_HALT |=>
      current_line_state_ff == `LSS_LS_HALT && !line_state_unknown_flag_ff)
      else $error("halt not taken");
a_no_early_lock:
   assert property (s_seed ##1 s_halt7 |=> line_state_unknown_flag_ff) else $error("locked too early");
a_state_holds_idle:
   assert property (!pair_valid |=> $stable(current_line_state_ff) &&
      $stable(line_state_unknown_flag_ff)) else $error("state moved without a pair");
endmodule // lss_status_asserts
bind lss_status lss_status_asserts #(.ADDR_W(ADDR_W)) lss_status_asserts_inst (.clock(clock),
   .rst_n(rst_n), .pair_valid(pair_valid), .pair_class(pair_class), .reg_addr(reg_addr),
   .repeat_filter_state(repeat_filter_state), .insertion_state(insertion_state), .reg_rd(reg_rd),
   .scrubbing_flag(scrubbing_flag), .conn_mgmt_state(conn_mgmt_state), .reg_rdata_ff(reg_rdata_ff),
   .current_line_state_ff(current_line_state_ff),
   .line_state_unknown_flag_ff(line_state_unknown_flag_ff));

// ---- bench/testbench.sv ----
// register-port testbench of the line state status bank
`timescale 1ns/1ps
`include "lss_map.vh"
`define CHK(v, e) begin checks_done++; if ((v) !== (e)) begin failures++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, v, e); end end
module testbench;
reg clock = 0, rst_n = 0, pair_valid = 0, scrubbing_flag = 0, reg_wr = 0, reg_rd = 0;
reg [2:0] pair_class = 0;
reg [1:0] repeat_filter_state = 0, insertion_state = 0;
reg [3:0] conn_mgmt_state = 0;
reg [4:0] reg_addr = 0;
reg [15:0] reg_wdata = 0, d;
wire [15:0] rdata;
wire [2:0] state;
wire unknown, irq;
integer failures = 0, checks_done = 0, i;
lss_status lss_status_inst (.clock(clock), .rst_n(rst_n), .pair_valid(pair_valid),
   .pair_class(pair_class), .repeat_filter_state(repeat_filter_state),
   .insertion_state(insertion_state), .scrubbing_flag(scrubbing_flag),
   .conn_mgmt_state(conn_mgmt_state), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata), .current_line_state_ff(state),
   .line_state_unknown_flag_ff(unknown), .irq_ff(irq));
always #20 clock = ~clock;
////////////////////////////////////////////////////////////////////////////////
// one-cycle strobes; read data is taken in the single cycle it stands
task wr(input [4:0] a, input [15:0] v);
   @(posedge clock); reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
   @(posedge clock); reg_wr <= 1'b0;
endtask
task rd(input [4:0] a, output [15:0] v);
   @(posedge clock); reg_addr <= a; reg_rd <= 1'b1;
   @(posedge clock); reg_rd <= 1'b0;
   #1 v = rdata;
endtask
// back-to-back pairs of one class
task send(input [2:0] c, input integer n);
   @(posedge clock); pair_class <= c; pair_valid <= 1'b1;
   repeat (n) @(posedge clock);
   pair_valid <= 1'b0;
   #1;
endtask
// one quiet pair, then n pairs of class c with no gap, so runs start from zero
task seeded(input [2:0] c, input integer n);
   @(posedge clock); pair_class <= `LSS_SYM_QUIET; pair_valid <= 1'b1;
   @(posedge clock); pair_class <= c;
   repeat (n) @(posedge clock);
   pair_valid <= 1'b0;
   #1;
endtask
// eight like pairs lock; counter parks at seven with the state bit up
task lock(input [2:0] c, input [2:0] code);
   send(c, 8);
   `CHK(state, code)
   rd(`LSS_ADDR_LINE_STATUS, d);
   `CHK(d, {8'h00, code, 1'b1, 1'b0, 3'h7})
endtask
task close_out;
   if (failures == 0 && checks_done > 0) $display("DONE - PASS");
   else $display("DONE - FAIL");
   $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// watchdog: the whole sequence needs well under a thousand cycles
initial begin
   #200000 failures++;
   close_out;
end
initial begin
   repeat (4) @(posedge clock);
   rst_n <= 1'b1;
   #1 `CHK({state, unknown, irq}, 5'h02)
   for (i = 0; i < 4; i++) begin
      @(posedge clock); repeat_filter_state <= i; insertion_state <= ~i;
      scrubbing_flag <= i[0]; conn_mgmt_state <= 4'h5 * i[3:0];
      rd(`LSS_ADDR_CONN_STATUS, d);
      `CHK(d, {i[1:0], ~i[1:0], i[0], 4'h5 * i[3:0], 7'h00})
   end
   // writes to the read-only words must leave the reported values alone
   wr(`LSS_ADDR_CONN_STATUS, 16'hffff); wr(`LSS_ADDR_LINE_STATUS, 16'hffff);
   rd(`LSS_ADDR_CONN_STATUS, d);
   `CHK(d, 16'hcf80)
   lock(`LSS_SYM_QUIET, `LSS_LS_QUIET); lock(`LSS_SYM_HALT, `LSS_LS_HALT);
   lock(`LSS_SYM_MASTER, `LSS_LS_MASTER); lock(`LSS_SYM_DATA, `LSS_LS_ACTIVE);
   lock(3'h2, `LSS_LS_NOISE); lock(`LSS_SYM_QUIET, `LSS_LS_QUIET);
   send(`LSS_SYM_IDLE, 2);
   `CHK(state, `LSS_LS_IDLE4)
   send(`LSS_SYM_IDLE, 6);
   `CHK(state, `LSS_LS_IDLE16)
   send(`LSS_SYM_HALT, 1);
   `CHK({state, unknown}, 4'hf)
   send(`LSS_SYM_HALT, 6);
   `CHK(unknown, 1'b1)
   send(`LSS_SYM_HALT, 1);
   `CHK({state, unknown}, 4'hc)
   // seeded runs with no gap, so the sequence checks see their antecedents
   seeded(`LSS_SYM_IDLE, 2);
   `CHK(state, `LSS_LS_IDLE4)
   seeded(`LSS_SYM_HALT, 7);
   `CHK(unknown, 1'b1)
   seeded(`LSS_SYM_HALT, 8);
   `CHK({state, unknown}, 4'hc)
   // interrupt path: both events pending, mask gates the level, one write clears the line change bit
   rd(`LSS_ADDR_INT_STATUS, d);
   `CHK({d, irq}, 17'h0_0006)
   wr(`LSS_ADDR_INT_MASK, 16'h0001);
   rd(`LSS_ADDR_INT_MASK, d);
   `CHK(d, 16'h0001)
   repeat (2) @(posedge clock);
   #1 `CHK(irq, 1'b1)
   wr(`LSS_ADDR_INT_STATUS, 16'h0001); repeat (2) @(posedge clock);
   #1 `CHK(irq, 1'b0)
   lock(`LSS_SYM_QUIET, `LSS_LS_QUIET); repeat (2) @(posedge clock);
   #1 `CHK(irq, 1'b1)
   wr(`LSS_ADDR_INT_MASK, 16'h0000); repeat (2) @(posedge clock);
   #1 `CHK(irq, 1'b0)
   rd(5'h05, d);
   `CHK(d, 16'h0000)
   close_out;
end
endmodule // testbench
